// >>> verilog/tat_map.svh
// register offsets, field positions, reset values and bus codes of the alert block
// assumes: included by bare name from the package and the top module
`ifndef TAT_MAP_SVH
`define TAT_MAP_SVH

// ==================================================
// register indices on the 2-wire link
`define TAT_IDX_MEAS        2'h0
`define TAT_IDX_CFG         2'h1
`define TAT_IDX_LOW         2'h2
`define TAT_IDX_HIGH        2'h3

// ==================================================
// configuration field positions
`define TAT_CFG_MIRROR      5
`define TAT_CFG_RATE_LO     6
`define TAT_CFG_RATE_HI     7
`define TAT_CFG_SLEEP       8
`define TAT_CFG_IRQ         9
`define TAT_CFG_LEVEL       10
`define TAT_CFG_FC_LO       11
`define TAT_CFG_FC_HI       12
`define TAT_CFG_FIXED_ONE   14
`define TAT_CFG_ONE_SHOT    15

// ==================================================
// reset values and the limit mask
`define TAT_RST_LOW         16'h2580
`define TAT_RST_HIGH        16'h2800
`define TAT_RST_RATE        2'h2
`define TAT_RST_MEAS        16'h0000
`define TAT_LIMIT_MASK      16'hFFF0

// ==================================================
// link codes
`define TAT_DEV_ADDR        7'h48
`define TAT_GCALL_ADDR      8'h00
`define TAT_GCALL_RESET     8'h06

`endif

// >>> verilog/tat_pkg.sv
// types shared by the alert block modules
// assumes: tat_map.svh is on the include path
package tat_pkg;
  `include "tat_map.svh"

  typedef logic signed [15:0] tat_code_t;

  typedef enum logic [3:0] {
    TAT_IDLE, TAT_ADDR, TAT_ACK_A, TAT_PTR, TAT_ACK_W, TAT_WR, TAT_GC, TAT_RD, TAT_ACK_R
  } tat_link_e;
endpackage

// >>> verilog/tat_alert_if.sv
// carrier between the register side and the fault filter
// assumes: both ends run on ref_clk
`timescale 1ns/1ns
interface tat_alert_if;
  import tat_pkg::*;
  tat_code_t  result;
  logic       valid;
  tat_code_t  low;
  tat_code_t  high;
  logic [1:0] n_code;
  logic       irq_style;
  logic       rd_clr;
  logic       sleep_clr;
  logic       alert;
  logic       phase;

  modport filt (input result, valid, low, high, n_code, irq_style, rd_clr, sleep_clr,
                output alert, phase);
  modport ctrl (output result, valid, low, high, n_code, irq_style, rd_clr, sleep_clr,
                input alert, phase);
endinterface

// >>> verilog/tat_alert_filter.sv
// consecutive-fault filter and alert state for both output styles
// assumes: one valid pulse per finished conversion, same clock as the register side
`timescale 1ns/1ns
module tat_alert_filter (
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  tat_alert_if.filt  al
);
  import tat_pkg::*;

  logic [1:0] cnt_r;
  logic       phase_r;
  logic       irq_r;
  logic       hit;
  logic       done;

  // ==================================================
  // fault test
  // phase 0 looks for the high event, phase 1 for the low one
  always_comb begin
    hit  = phase_r ? (al.result <= al.low) : (al.result >= al.high);
    done = al.valid && hit && (cnt_r == al.n_code);
  end

  // ==================================================
  // consecutive count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 2'h0;
    end else if (al.valid) begin
      if (!hit || done) begin
        cnt_r <= 2'h0;
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end

  // ==================================================
  // state toggles between high and low events in both styles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= 1'b0;
    end else if (done) begin
      phase_r <= ~phase_r;
    end
  end

  // ==================================================
  // interrupt-style latch; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else if (done && al.irq_style) begin
      irq_r <= 1'b1;
    end else if (al.rd_clr || al.sleep_clr || !al.irq_style) begin
      irq_r <= 1'b0;
    end
  end

  assign al.alert = al.irq_style ? irq_r : phase_r;
  assign al.phase = phase_r;
endmodule

// >>> verilog/tat_top.sv
// alert and threshold logic with its 2-wire register port
// assumes: converter hands one result with a one-cycle done pulse on ref_clk;
// scl and sda arrive asynchronous and are filtered here
`timescale 1ns/1ns
`include "tat_map.svh"
module tat_top (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          scl,
  input  wire logic          sda_i,
  output logic               sda_o,
  output logic               sda_oe,
  input  wire logic          conv_done,
  input  wire tat_pkg::tat_code_t conv_result,
  output logic               conv_start,
  output logic               conv_cont,
  output logic               conv_slow,
  output logic [1:0]         conv_rate,
  output logic               overtemp_signal_pin
);
  import tat_pkg::*;

  tat_alert_if al ();

  logic [2:0] scl_s_r, sda_s_r;
  logic       scl_f_r, sda_f_r;
  logic       scl_rise, scl_fall, start_c, stop_c;
  tat_link_e  st_r;
  logic [3:0] bcnt_r;
  logic [7:0] sh_r, tx_r, wbuf_r;
  logic       rw_r, gc_r, byte_r, nack_r;
  logic [1:0] ptr_r;
  logic       wr_stb_r, rd_done_r, greset_r;
  logic [15:0] wdata_r;
  tat_code_t  low_threshold_r, high_threshold_r, meas_r;
  logic [1:0] fault_count_field_r, rate_r;
  logic       sleep_bit_r, irq_style_bit_r, active_level_bit_r, busy_r;
  logic       sleep_clr_r;
  logic [15:0] rword;

  // ==================================================
  // read word of a register index
  function automatic logic [15:0] rd_word(input logic [1:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    unique case (idx)
      `TAT_IDX_MEAS: w = meas_r;
      `TAT_IDX_CFG: begin
        w[`TAT_CFG_MIRROR]    = active_level_bit_r ? al.phase : ~al.phase;
        w[`TAT_CFG_RATE_HI:`TAT_CFG_RATE_LO] = rate_r;
        w[`TAT_CFG_SLEEP]     = sleep_bit_r;
        w[`TAT_CFG_IRQ]       = irq_style_bit_r;
        w[`TAT_CFG_LEVEL]     = active_level_bit_r;
        w[`TAT_CFG_FC_HI:`TAT_CFG_FC_LO] = fault_count_field_r;
        w[`TAT_CFG_FIXED_ONE] = 1'b1;
        w[`TAT_CFG_ONE_SHOT]  = busy_r;
      end
      `TAT_IDX_LOW:  w = low_threshold_r & `TAT_LIMIT_MASK;
      `TAT_IDX_HIGH: w = high_threshold_r & `TAT_LIMIT_MASK;
    endcase
    return w;
  endfunction

  // one decoded read word, sliced by the link engine
  always_comb begin
    rword = rd_word(ptr_r);
  end

  // ==================================================
  // pin filters: a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl};
      sda_s_r <= {sda_s_r[1:0], sda_i};
      if (scl_s_r[1] == scl_s_r[2]) begin
        scl_f_r <= scl_s_r[2];
      end
      if (sda_s_r[1] == sda_s_r[2]) begin
        sda_f_r <= sda_s_r[2];
      end
    end
  end

  always_comb begin
    scl_rise = (scl_s_r[1] == scl_s_r[2]) && scl_s_r[2] && !scl_f_r;
    scl_fall = (scl_s_r[1] == scl_s_r[2]) && !scl_s_r[2] && scl_f_r;
    start_c  = scl_f_r && (sda_s_r[1] == sda_s_r[2]) && !sda_s_r[2] && sda_f_r;
    stop_c   = scl_f_r && (sda_s_r[1] == sda_s_r[2]) && sda_s_r[2] && !sda_f_r;
  end

  // ==================================================
  // link engine: bytes msb first, register words high byte first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= TAT_IDLE;
      bcnt_r    <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      wbuf_r    <= 8'h00;
      rw_r      <= 1'b0;
      gc_r      <= 1'b0;
      byte_r    <= 1'b0;
      nack_r    <= 1'b0;
      ptr_r     <= 2'h0;
      sda_oe    <= 1'b0;
      wr_stb_r  <= 1'b0;
      rd_done_r <= 1'b0;
      greset_r  <= 1'b0;
      wdata_r   <= 16'h0000;
    end else begin
      wr_stb_r  <= 1'b0;
      rd_done_r <= 1'b0;
      greset_r  <= 1'b0;
      if (start_c) begin
        st_r   <= TAT_ADDR;
        bcnt_r <= 4'h0;
        sda_oe <= 1'b0;
        byte_r <= 1'b0;
      end else if (stop_c) begin
        st_r   <= TAT_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        sh_r <= {sh_r[6:0], sda_f_r};
        if (st_r == TAT_ACK_R) begin
          nack_r <= sda_f_r;
        end else if (bcnt_r != 4'h8) begin
          bcnt_r <= bcnt_r + 4'h1;
        end
      end else if (scl_fall) begin
        unique case (st_r)
          TAT_ADDR: if (bcnt_r == 4'h8) begin
            if (sh_r[7:1] == `TAT_DEV_ADDR || sh_r == `TAT_GCALL_ADDR) begin
              st_r   <= TAT_ACK_A;
              rw_r   <= sh_r[0];
              gc_r   <= (sh_r == `TAT_GCALL_ADDR);
              sda_oe <= 1'b1;
            end else begin
              st_r <= TAT_IDLE;
            end
          end
          TAT_ACK_A: begin
            bcnt_r <= 4'h0;
            if (rw_r) begin
              tx_r   <= {rword[14:8], 1'b0};
              sda_oe <= ~rword[15];
              st_r   <= TAT_RD;
            end else begin
              sda_oe <= 1'b0;
              st_r   <= gc_r ? TAT_GC : TAT_PTR;
            end
          end
          TAT_PTR, TAT_GC, TAT_WR: if (bcnt_r == 4'h8) begin
            sda_oe <= 1'b1;
            st_r   <= TAT_ACK_W;
            if (st_r == TAT_PTR) begin
              ptr_r  <= sh_r[1:0];
              byte_r <= 1'b0;
            end else if (st_r == TAT_GC) begin
              greset_r <= (sh_r == `TAT_GCALL_RESET);
            end else if (!byte_r) begin
              wbuf_r <= sh_r;
              byte_r <= 1'b1;
            end else begin
              wdata_r  <= {wbuf_r, sh_r};
              wr_stb_r <= 1'b1;
              byte_r   <= 1'b0;
            end
          end
          TAT_ACK_W: begin
            sda_oe <= 1'b0;
            bcnt_r <= 4'h0;
            st_r   <= gc_r ? TAT_IDLE : TAT_WR;
          end
          TAT_RD: if (bcnt_r == 4'h8) begin
            sda_oe <= 1'b0;
            st_r   <= TAT_ACK_R;
          end else begin
            sda_oe <= ~tx_r[7];
            tx_r   <= {tx_r[6:0], 1'b0};
          end
          TAT_ACK_R: begin
            rd_done_r <= byte_r || nack_r;
            bcnt_r    <= 4'h0;
            if (nack_r) begin
              st_r <= TAT_IDLE;
            end else begin
              st_r   <= TAT_RD;
              byte_r <= ~byte_r;
              // low byte follows the high byte, then the word repeats
              tx_r   <= byte_r ? {rword[14:8], 1'b0} : {rword[6:0], 1'b0};
              sda_oe <= byte_r ? ~rword[15] : ~rword[7];
            end
          end
          TAT_IDLE: st_r <= TAT_IDLE;
        endcase
      end
    end
  end

  // ==================================================
  // limit registers, written as whole words after the low byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_threshold_r  <= `TAT_RST_LOW;
      high_threshold_r <= `TAT_RST_HIGH;
    end else if (wr_stb_r && ptr_r == `TAT_IDX_LOW) begin
      low_threshold_r <= wdata_r & `TAT_LIMIT_MASK;
    end else if (wr_stb_r && ptr_r == `TAT_IDX_HIGH) begin
      high_threshold_r <= wdata_r & `TAT_LIMIT_MASK;
    end
  end

  // ==================================================
  // configuration; the general reset restores defaults and drops interrupt style
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_r              <= `TAT_RST_RATE;
      sleep_bit_r         <= 1'b0;
      irq_style_bit_r     <= 1'b0;
      active_level_bit_r  <= 1'b0;
      fault_count_field_r <= 2'h0;
    end else if (greset_r) begin
      rate_r              <= `TAT_RST_RATE;
      sleep_bit_r         <= 1'b0;
      irq_style_bit_r     <= 1'b0;
      active_level_bit_r  <= 1'b0;
      fault_count_field_r <= 2'h0;
    end else if (wr_stb_r && ptr_r == `TAT_IDX_CFG) begin
      rate_r              <= wdata_r[`TAT_CFG_RATE_HI:`TAT_CFG_RATE_LO];
      sleep_bit_r         <= wdata_r[`TAT_CFG_SLEEP];
      irq_style_bit_r     <= wdata_r[`TAT_CFG_IRQ];
      active_level_bit_r  <= wdata_r[`TAT_CFG_LEVEL];
      fault_count_field_r <= wdata_r[`TAT_CFG_FC_HI:`TAT_CFG_FC_LO];
    end
  end

  // ==================================================
  // one-shot control and converter handshake
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r      <= 1'b0;
      conv_start  <= 1'b0;
      conv_slow   <= 1'b0;
      sleep_clr_r <= 1'b0;
      meas_r      <= `TAT_RST_MEAS;
    end else begin
      conv_start  <= 1'b0;
      sleep_clr_r <= wr_stb_r && ptr_r == `TAT_IDX_CFG && wdata_r[`TAT_CFG_SLEEP];
      if (conv_done) begin
        meas_r    <= conv_result;
        busy_r    <= 1'b0;
        conv_slow <= 1'b0;
      end else if (wr_stb_r && ptr_r == `TAT_IDX_CFG && wdata_r[`TAT_CFG_SLEEP] &&
                   wdata_r[`TAT_CFG_ONE_SHOT] && !busy_r) begin
        // sleep and one-shot may be set in the same write; retrigger waits for done
        busy_r     <= 1'b1;
        conv_start <= 1'b1;
      end
      if (wr_stb_r && ptr_r == `TAT_IDX_CFG && wdata_r[`TAT_CFG_SLEEP] && !sleep_bit_r) begin
        conv_slow <= 1'b1;
      end
    end
  end

  // ==================================================
  // filter hookup and pin drive
  assign al.result    = conv_result;
  assign al.valid     = conv_done;
  assign al.low       = low_threshold_r;
  assign al.high      = high_threshold_r;
  assign al.n_code    = fault_count_field_r;
  assign al.irq_style = irq_style_bit_r;
  assign al.rd_clr    = rd_done_r;
  assign al.sleep_clr = sleep_clr_r;

  tat_alert_filter u_filt (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .al      (al)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_signal_pin <= 1'b1;
      conv_cont           <= 1'b1;
      conv_rate           <= `TAT_RST_RATE;
      sda_o               <= 1'b0;
    end else begin
      overtemp_signal_pin <= active_level_bit_r ? al.alert : ~al.alert;
      conv_cont           <= ~sleep_bit_r;
      conv_rate           <= rate_r;
      sda_o               <= 1'b0;
    end
  end
endmodule

// >>> tb/tat_host_model.sv
// 2-wire bus host model: frames and bytes at a 160 ns bit period
// assumes: sda is the resolved open-drain line with a pull-up
`timescale 1ns/1ns
module tat_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // ==================================================
  // frame tasks; scl stands high between frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start();
    sda_low = 1'b0;
    #100 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask

  // data moves 30 ns after scl falls, so its filtered edge never meets a filtered scl edge
  task automatic stop();
    #30 sda_low = 1'b1;
    #70 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask

  // long low phase so the device drops its ack before the next rise
  task automatic byte_io(input logic [7:0] tx, input logic mack,
                         output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    for (int i = 8; i >= 0; i--) begin
      #30 sda_low = (i > 0) ? !tx[i-1] : mack;
      #80 scl = 1'b1;
      #30 sh = {sh[7:0], sda};
      #20 scl = 1'b0;
    end
    rx = sh[8:1];
    ack = !sh[0];
  endtask
endmodule

// >>> tb/tat_top_sva.sv
// assertions on the ports of the alert block
// assumes: bound to tat_top, one ref_clk domain
`timescale 1ns/1ns
module tat_top_sva (
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic               scl,
  input wire logic               sda_i,
  input wire logic               sda_o,
  input wire logic               sda_oe,
  input wire logic               conv_done,
  input wire tat_pkg::tat_code_t conv_result,
  input wire logic               conv_start,
  input wire logic               conv_cont,
  input wire logic               conv_slow,
  input wire logic [1:0]         conv_rate,
  input wire logic               overtemp_signal_pin
);
  import tat_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ==================================================
  // helpers: cycles since the last scl move, one-shot in flight
  logic       scl_q;
  logic [7:0] idle_cnt;
  logic       busy_h;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q    <= 1'b1;
      idle_cnt <= 8'h00;
    end else begin
      scl_q    <= scl;
      idle_cnt <= (scl != scl_q) ? 8'h00 : idle_cnt + {7'h00, idle_cnt != 8'hFF};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) busy_h <= 1'b0;
    else if (conv_start) busy_h <= 1'b1;
    else if (conv_done) busy_h <= 1'b0;
  end

  // ==================================================
  // idle link: pin moves only two cycles after a result
  a_pin_cause: assert property (
    $changed(overtemp_signal_pin) && idle_cnt > 8'h1E |-> $past(conv_done, 2))
    else $error("alert pin moved without a result");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_start_sleep: assert property (conv_start |=> !conv_cont)
    else $error("one-shot start while converting continuously");
  a_start_busy: assert property (conv_start |-> !busy_h)
    else $error("second start before the result");
  a_cont_write: assert property ($changed(conv_cont) |-> idle_cnt < 8'h1E)
    else $error("mode changed without a write");
  a_slow_sleep: assert property ($rose(conv_slow) |=> !conv_cont)
    else $error("slow flag outside sleep");
  a_idle_release: assert property (idle_cnt > 8'h1E |-> !sda_oe)
    else $error("data line held on an idle link");
  a_sda_zero: assert property (sda_oe |-> !sda_o)
    else $error("data line driven high");

  c_one_shot: cover property (conv_start);
  c_alert: cover property ($changed(overtemp_signal_pin));
  c_ack: cover property ($rose(sda_oe));
endmodule

bind tat_top tat_top_sva i_sva (
  .ref_clk, .rst_n, .scl, .sda_i, .sda_o, .sda_oe, .conv_done, .conv_result,
  .conv_start, .conv_cont, .conv_slow, .conv_rate, .overtemp_signal_pin
);

// >>> tb/temp_alert_threshold_logic_tb.sv
// self-checking bench: link host, converter stub, reference alert model
// assumes: tat_top on a 50 MHz ref_clk, bus pull-up resolved here
`timescale 1ns/1ns
module temp_alert_threshold_logic_tb;
  import tat_pkg::*;
  logic        ref_clk;
  logic        rst_n;
  logic        conv_done;
  tat_code_t   conv_result;
  logic        scl, host_low, sda_o, sda_oe, conv_start, conv_cont, conv_slow, pin;
  logic [1:0]  conv_rate;
  logic [15:0] d;
  logic [31:0] seed = 32'h000009D6;
  logic [31:0] x;
  wire         sda_line = !(host_low || sda_oe);
  int failures = 0, num_checks = 0, starts = 0, n0, r;
  int lo_m = 'h2580, hi_m = 'h2800, n_m = 1, ph_m, lat_m, irq_m, pol_m, slp_m, cnt_m;

  tat_top i_dut (.ref_clk, .rst_n, .scl, .sda_i(sda_line), .sda_o, .sda_oe, .conv_done,
    .conv_result, .conv_start, .conv_cont, .conv_slow, .conv_rate,
    .overtemp_signal_pin(pin));
  tat_host_model i_host (.scl, .sda_low(host_low), .sda(sda_line));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (conv_start) starts++;
  // watchdog: the run needs about 0.8 ms, kept under 100k cycles
  initial begin
    #1900000 failures++;
    test_done();
  end

  // ==================================================
  // compare, link and converter tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic pin_chk();
    logic act;
    act = irq_m ? lat_m[0] : ph_m[0];
    chk("alert pin", {15'h0, pol_m[0] ? act : !act}, {15'h0, pin});
  endtask
  function automatic logic [15:0] cfg_exp(input logic os);
    return {os, 2'b10, 2'(n_m - 1), pol_m[0], irq_m[0], slp_m[0], 2'b10,
            pol_m[0] ? ph_m[0] : !ph_m[0], 5'h00};
  endfunction
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tx(input logic [7:0] b);
    logic [7:0] rx;
    logic       a;
    i_host.byte_io(b, 1'b0, rx, a);
    chk("ack", 16'h0001, {15'h0, a});
  endtask
  task automatic wr(input logic [1:0] idx, input logic [15:0] v);
    i_host.start();
    tx(8'h90);
    tx({6'h00, idx});
    tx(v[15:8]);
    tx(v[7:0]);
    i_host.stop();
  endtask
  task automatic rd(input logic [1:0] idx, output logic [15:0] v);
    logic [7:0] hb;
    logic [7:0] lb;
    logic       a;
    wr_ptr(idx);
    i_host.start();
    tx(8'h91);
    i_host.byte_io(8'hFF, 1'b1, hb, a);
    i_host.byte_io(8'hFF, 1'b0, lb, a);
    i_host.stop();
    v = {hb, lb};
    lat_m = 0;
    repeat (4) @(posedge ref_clk);
    #2 pin_chk();
  endtask
  task automatic wr_ptr(input logic [1:0] idx);
    i_host.start();
    tx(8'h90);
    tx({6'h00, idx});
    i_host.stop();
  endtask
  task automatic set_cfg(input logic os, input logic [1:0] fc, input logic active_level_bit,
                         input logic irq, input logic slp);
    wr(2'h1, {os, 2'b10, fc, active_level_bit, irq, slp, 8'h80});
    if (!irq || !irq_m || slp) lat_m = 0;
    n_m = fc + 1;
    pol_m = active_level_bit;
    irq_m = irq;
    slp_m = slp;
    repeat (4) @(posedge ref_clk);
    #2 pin_chk();
  endtask
  task automatic conv(input int v);
    @(posedge ref_clk);
    #2 conv_done = 1'b1;
    conv_result = 16'(v);
    @(posedge ref_clk);
    #2 conv_done = 1'b0;
    if (ph_m ? v <= lo_m : v >= hi_m) cnt_m++;
    else cnt_m = 0;
    if (cnt_m == n_m) begin
      ph_m = !ph_m;
      lat_m = 1;
      cnt_m = 0;
    end
    repeat (3) @(posedge ref_clk);
    #2 pin_chk();
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    conv_done = 1'b0;
    conv_result = 16'h0000;
    repeat (16) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(2'h2, d);
    chk("low limit", 16'h2580, d);
    rd(2'h3, d);
    chk("high limit", 16'h2800, d);
    rd(2'h1, d);
    chk("config", cfg_exp(1'b0), d);
    chk("rate", 16'h0002, {14'h0, conv_rate});
    wr(2'h3, 16'h0C8F);
    wr(2'h2, 16'h064A);
    hi_m = 'h0C80;
    lo_m = 'h0640;
    rd(2'h3, d);
    chk("high limit", 16'h0C80, d);
    rd(2'h2, d);
    chk("low limit", 16'h0640, d);
    // every count code, both levels, both styles, random results
    for (int k = 0; k < 16; k++) begin
      set_cfg(1'b0, 2'(k), k[2], k[3], 1'b0);
      conv('h0900);
      for (int j = 0; j < 24; j++) begin
        x = xs();
        r = (x[1:0] == 2'h0) ? hi_m : (x[1:0] == 2'h1) ? lo_m : 'h0540 + x[15:4] % 'h0840;
        conv(r);
        if (irq_m && x[5:4] == 2'h0) begin
          rd(2'h2, d);
          chk("low limit", 16'(lo_m), d);
        end
      end
      rd(2'h1, d);
      chk("config", cfg_exp(1'b0), d);
    end
    set_cfg(1'b0, 2'h0, 1'b0, 1'b1, 1'b0);
    conv('h0900);
    conv(hi_m);
    conv(lo_m);
    set_cfg(1'b0, 2'h0, 1'b0, 1'b1, 1'b1);
    chk("cont", 16'h0000, {15'h0, conv_cont});
    chk("slow", 16'h0001, {15'h0, conv_slow});
    n0 = starts;
    set_cfg(1'b1, 2'h0, 1'b0, 1'b1, 1'b1);
    chk("starts", 16'(n0 + 1), 16'(starts));
    rd(2'h1, d);
    chk("config", cfg_exp(1'b1), d);
    conv('h0900);
    rd(2'h1, d);
    chk("config", cfg_exp(1'b0), d);
    chk("slow", 16'h0000, {15'h0, conv_slow});
    rd(2'h0, d);
    chk("measured", 16'h0900, d);
    set_cfg(1'b1, 2'h0, 1'b0, 1'b1, 1'b1);
    chk("starts", 16'(n0 + 2), 16'(starts));
    conv('h0900);
    i_host.start();
    tx(8'h00);
    tx(8'h06);
    i_host.stop();
    irq_m = 0;
    pol_m = 0;
    n_m = 1;
    slp_m = 0;
    lat_m = 0;
    rd(2'h1, d);
    chk("config", cfg_exp(1'b0), d);
    // mid-run reset must bring back the default limits and a quiet alert
    @(posedge ref_clk);
    #2 rst_n = 1'b0;
    repeat (16) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    lo_m = 'h2580;
    hi_m = 'h2800;
    ph_m = 0;
    cnt_m = 0;
    repeat (8) @(posedge ref_clk);
    rd(2'h2, d);
    chk("low limit", 16'h2580, d);
    rd(2'h3, d);
    chk("high limit", 16'h2800, d);
    rd(2'h1, d);
    chk("config", cfg_exp(1'b0), d);
    test_done();
  end
endmodule
